/* logic/wdg_pkg.sv */
// constants shared by the digital watchdog reset block
package wdg_pkg;
   // register bus
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] ADDR_COUNT_CTL = 8'hD8; // watchdog_counter_control
   localparam logic [7:0] ADDR_STATUS = 8'hDC;    // block state, read only
   // watchdog_counter_control layout
   localparam logic [7:0] COUNT_CTL_RST = 8'hFE;
   localparam int BIT_ACTIVATE = 0;
   localparam int BIT_SOFT_RESET = 1;
   localparam int BIT_COUNT_MSB = 2;     // count_bit_msb
   localparam int BIT_COUNT_LSB = 7;     // count_bit_lsb
   localparam int CNT_W = 7;             // physical downcounter width
   localparam int CNT_TRIG_BIT = 6;      // falling edge of this bit fires reset
   localparam logic [6:0] CNT_RST = 7'h7F;
   // status layout
   localparam int ST_SYS_RESET = 0;
   localparam int ST_NMI_MODE = 1;
   localparam int ST_STOP = 2;
   localparam int ST_WAIT = 3;
   localparam int ST_HW_OPT = 4;
   localparam int ST_WDG_CAUSE = 5;
   // timing, in mclk cycles
   localparam int CORE_DIV = 12;         // counter clock is mclk / 12
   localparam int PRESCALE = 256;        // 12 * 256 = 3072 cycles per step
   localparam int STEP_CYCLES = CORE_DIV * PRESCALE;
   localparam int STAB_CYCLES = 2048;    // stabilisation delay after reset
   localparam logic [3:0] DIV_LAST = 4'(CORE_DIV - 1);
   localparam logic [7:0] PRE_LAST = 8'(PRESCALE - 1);
   localparam logic [10:0] STAB_LAST = 11'(STAB_CYCLES - 1);
   // reset vector in program space
   localparam logic [11:0] RESET_VECTOR = 12'hFFE;
   // internal reset sequencer
   typedef enum logic [1:0] {RS_HOLD, RS_DELAY, RS_RUN} wdg_rst_e;
endpackage : wdg_pkg

/* logic/wdg_top.sv */
// digital watchdog with internal reset sequencing and avalon-mm registers
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
module wdg_top
   import wdg_pkg::*;
(
   input wire logic mclk,                         // system clock, 100 MHz
   input wire logic rst_n,                        // power-on reset, sync, low
   input wire logic ext_reset_n,                  // reset pin level, low active
   input wire logic hw_option,                    // 1 = hardware activation strap
   input wire logic [wdg_pkg::ADDR_W-1:0] address, // avalon byte address
   input wire logic read,                         // avalon read request
   input wire logic write,                        // avalon write request
   input wire logic [wdg_pkg::DATA_W-1:0] writedata, // avalon write data
   input wire logic [3:0] byteenable,             // avalon byte lanes
   output logic [wdg_pkg::DATA_W-1:0] readdata,   // avalon read data
   output logic waitrequest,                      // avalon stall
   input wire logic stop_req,                     // core executes stop, pulse
   input wire logic wake_irq,                     // interrupt ends stop or wait
   input wire logic return_from_interrupt,                         // return_from_interrupt, pulse
   input wire logic irq_pending,                  // a maskable request waits
   output logic sys_reset,                        // internal reset, high active
   output logic stack_clear,                      // clear return stack, pulse
   output logic pc_load,                          // load pc with vector, pulse
   output logic [11:0] pc_vector,                 // address to load
   output logic nmi_mode,                         // core in nmi mode
   output logic irq_service,                      // serve pending irq, pulse
   output logic resume_next,                      // continue after return_from_interrupt, pulse
   output logic osc_halt,                         // stop mode, oscillator off
   output logic wait_mode                         // wait mode, clocks run
);
   import wdg_pkg::*;

   // register map decode, used by read and write paths
   function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      is_addr = (a == off);
   endfunction

   wdg_rst_e rs_r, rs_nxt;
   logic [10:0] stab_r, stab_nxt;
   logic [3:0] div_r, div_nxt;
   logic [7:0] pre_r, pre_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic act_r, act_nxt;
   logic opt_r, opt_nxt;
   logic cause_r, cause_nxt;
   logic nmi_r, nmi_nxt;
   logic stop_r, stop_nxt;
   logic wait_r, wait_nxt;
   logic init_r, init_nxt;
   logic svc_r, svc_nxt;
   logic res_r, res_nxt;
   logic ack_r, ack_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic in_reset, running, active, tick, wr_ok, wr_cnt, soft_fire, cnt_fire, wdg_fire;
   logic [CNT_W-1:0] cnt_dec, cnt_wr;
   logic [7:0] reg_view;
   logic [7:0] status_view;

   assign in_reset = (rs_r != RS_RUN);
   assign running = !in_reset;
   // hardware strap forces the watchdog on
   assign active = opt_r | act_r;

   // bus: one wait cycle, answered on the cycle after the request
   assign waitrequest = (read | write) & ~ack_r;
   assign wr_ok = write & ack_r & running;
   assign wr_cnt = wr_ok & is_addr(address, ADDR_COUNT_CTL) & byteenable[0];

   // register bits are the physical count in reverse order, shifted up by one
   generate
      for (genvar i = 0; i < CNT_W - 1; i++) begin : g_map
         assign reg_view[BIT_COUNT_LSB - i] = cnt_r[i];
         assign cnt_wr[i] = writedata[BIT_COUNT_LSB - i];
      end
   endgenerate
   assign reg_view[BIT_SOFT_RESET] = cnt_r[CNT_TRIG_BIT];
   assign reg_view[BIT_ACTIVATE] = active;
   assign cnt_wr[CNT_TRIG_BIT] = writedata[BIT_SOFT_RESET];

   assign status_view = {2'h0, cause_r, opt_r, wait_r, stop_r, nmi_r, in_reset};

   // a zero written to the soft reset bit fires at once, in either option
   assign soft_fire = wr_cnt & ~writedata[BIT_SOFT_RESET];
   assign cnt_dec = cnt_r - 7'h01;
   // only the falling of the top bit matters; the six bits below set the period
   assign cnt_fire = tick & active & cnt_r[CNT_TRIG_BIT] & ~cnt_dec[CNT_TRIG_BIT];
   assign wdg_fire = running & (soft_fire | cnt_fire);

   // divide by twelve, then by 256, so one step is 3072 cycles
   assign tick = running & ~stop_r & (div_r == DIV_LAST) & (pre_r == PRE_LAST);

   // prescaler chain; it freezes in stop so the count resumes unchanged
   always_comb begin
      div_nxt = div_r;
      pre_nxt = pre_r;
      if (in_reset) begin
         div_nxt = 4'h0;
         pre_nxt = 8'h00;
      end else if (!stop_r) begin
         div_nxt = (div_r == DIV_LAST) ? 4'h0 : div_r + 4'h1;
         if (div_r == DIV_LAST) begin
            pre_nxt = pre_r + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         div_r <= 4'h0;
         pre_r <= 8'h00;
      end else begin
         div_r <= div_nxt;
         pre_r <= pre_nxt;
      end
   end

   // internal reset sequencer: hold while the pin is low, then stabilise
   always_comb begin
      rs_nxt = rs_r;
      stab_nxt = stab_r;
      case (rs_r)
         RS_HOLD: begin
            stab_nxt = STAB_LAST;
            if (ext_reset_n) begin
               rs_nxt = RS_DELAY;
            end
         end
         RS_DELAY: begin
            if (!ext_reset_n) begin
               rs_nxt = RS_HOLD;
            end else if (stab_r == 11'h000) begin
               rs_nxt = RS_RUN;
            end else begin
               stab_nxt = stab_r - 11'h001;
            end
         end
         RS_RUN: begin
            // the watchdog takes the same path as the pin, delay included
            if (!ext_reset_n || wdg_fire) begin
               rs_nxt = RS_HOLD;
            end
         end
         default: rs_nxt = RS_HOLD;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rs_r <= RS_HOLD;
         stab_r <= STAB_LAST;
      end else begin
         rs_r <= rs_nxt;
         stab_r <= stab_nxt;
      end
   end

   // watchdog register and option strap
   always_comb begin
      cnt_nxt = cnt_r;
      act_nxt = act_r;
      opt_nxt = opt_r;
      cause_nxt = cause_r;
      if (in_reset) begin
         // every reset reloads the register with its longest period
         cnt_nxt = CNT_RST;
         act_nxt = COUNT_CTL_RST[BIT_ACTIVATE];
         // the strap is caught by clocked logic while reset is held
         opt_nxt = hw_option;
      end else if (wr_cnt) begin
         cnt_nxt = cnt_wr;
         // once set, only a reset can clear the activation bit
         act_nxt = act_r | writedata[BIT_ACTIVATE];
      end else if (tick) begin
         // with activation clear the counter is just a free 7-bit timer
         cnt_nxt = cnt_dec;
      end
      if (wdg_fire) begin
         cause_nxt = 1'b1;
      end else if (rs_r == RS_HOLD && !ext_reset_n) begin
         cause_nxt = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt_r <= CNT_RST;
         act_r <= 1'b0;
         opt_r <= 1'b0;
         cause_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         act_r <= act_nxt;
         opt_r <= opt_nxt;
         cause_r <= cause_nxt;
      end
   end

   // core side: initialisation pulse, nmi mode, return_from_interrupt and low-power modes
   always_comb begin
      nmi_nxt = nmi_r;
      stop_nxt = stop_r;
      wait_nxt = wait_r;
      init_nxt = 1'b0;
      svc_nxt = 1'b0;
      res_nxt = 1'b0;
      if (in_reset) begin
         nmi_nxt = 1'b1;
         stop_nxt = 1'b0;
         wait_nxt = 1'b0;
         init_nxt = (rs_nxt == RS_RUN);
      end else begin
         if (return_from_interrupt && nmi_r) begin
            nmi_nxt = 1'b0;
            svc_nxt = irq_pending;
            res_nxt = ~irq_pending;
         end
         if (stop_r || wait_r) begin
            if (wake_irq) begin
               stop_nxt = 1'b0;
               wait_nxt = 1'b0;
            end
         end else if (stop_req) begin
            // a running watchdog must keep counting, so stop degrades to wait
            stop_nxt = ~active;
            wait_nxt = active;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         nmi_r <= 1'b1;
         stop_r <= 1'b0;
         wait_r <= 1'b0;
         init_r <= 1'b0;
         svc_r <= 1'b0;
         res_r <= 1'b0;
      end else begin
         nmi_r <= nmi_nxt;
         stop_r <= stop_nxt;
         wait_r <= wait_nxt;
         init_r <= init_nxt;
         svc_r <= svc_nxt;
         res_r <= res_nxt;
      end
   end

   // bus answer; unmapped addresses read zero and ignore writes
   always_comb begin
      ack_nxt = (read | write) & ~ack_r;
      rdata_nxt = rdata_r;
      if (read && !ack_r) begin
         if (is_addr(address, ADDR_COUNT_CTL)) begin
            rdata_nxt = {24'h000000, reg_view};
         end else if (is_addr(address, ADDR_STATUS)) begin
            rdata_nxt = {24'h000000, status_view};
         end else begin
            rdata_nxt = 32'h00000000;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
         rdata_r <= 32'h00000000;
      end else begin
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign readdata = rdata_r;
   assign sys_reset = in_reset;
   assign stack_clear = init_r;
   assign pc_load = init_r;
   assign pc_vector = RESET_VECTOR;
   assign nmi_mode = nmi_r;
   assign irq_service = svc_r;
   assign resume_next = res_r;
   assign osc_halt = stop_r;
   assign wait_mode = wait_r;
endmodule // wdg_top
`default_nettype wire

/* bench/wdg_top_monitor.sv */
// concurrent checks on the watchdog reset block ports
`timescale 1ns/100ps
`default_nettype none
module wdg_top_monitor
   import wdg_pkg::*;
(
   input wire logic mclk, // clock
   input wire logic rst_n, // sync reset, low
   input wire logic ext_reset_n, // reset pin, low
   input wire logic [wdg_pkg::ADDR_W-1:0] address, // bus address
   input wire logic read, // bus read
   input wire logic write, // bus write
   input wire logic [wdg_pkg::DATA_W-1:0] writedata, // bus data
   input wire logic [3:0] byteenable, // bus lanes
   input wire logic waitrequest, // bus stall
   input wire logic stop_req, // stop pulse
   input wire logic wake_irq, // wake request
   input wire logic return_from_interrupt, // return pulse
   input wire logic irq_pending, // pending request
   input wire logic sys_reset, // internal reset
   input wire logic stack_clear, // stack clear pulse
   input wire logic pc_load, // vector load pulse
   input wire logic [11:0] pc_vector, // reset vector
   input wire logic nmi_mode, // nmi mode
   input wire logic irq_service, // serve pulse
   input wire logic resume_next, // resume pulse
   input wire logic osc_halt, // stop mode
   input wire logic wait_mode // wait mode
);
   logic [11:0] hi_cnt_r, hi_cnt_nxt;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // cycles of internal reset since the pin let go; a fixed hold, so a counter not a wait
   always_comb begin
      hi_cnt_nxt = (sys_reset && ext_reset_n) ? hi_cnt_r + 12'h001 : 12'h000;
   end
   always_ff @(posedge mclk) begin
      hi_cnt_r <= rst_n ? hi_cnt_nxt : 12'h000;
   end
   sequence sr_clear_s;
      write && !waitrequest && address == ADDR_COUNT_CTL && byteenable[0] &&
         !writedata[1] && !sys_reset;
   endsequence
   wait_once_a: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
      else $error("bus answer not after exactly one wait cycle");
   vector_load_a: assert property ($fell(sys_reset) |->
      pc_load && stack_clear && nmi_mode && pc_vector == RESET_VECTOR)
      else $error("no vector load at reset end");
   return_from_interrupt_exit_a: assert property (return_from_interrupt && nmi_mode && !sys_reset |=> !nmi_mode &&
      irq_service == $past(irq_pending) && resume_next == !$past(irq_pending))
      else $error("return from nmi mode mishandled");
   pin_hold_a: assert property (!ext_reset_n |=> sys_reset)
      else $error("pin reset did not hold internal reset");
   stab_len_a: assert property ($fell(sys_reset) |->
      hi_cnt_r >= 12'h7FF && hi_cnt_r <= 12'h803) else $error("stabilisation hold wrong length");
   soft_fire_a: assert property (sr_clear_s |-> ##[1:2] sys_reset)
      else $error("soft reset bit clear did not reset");
   stop_enter_a: assert property (stop_req && !sys_reset && !osc_halt && !wait_mode |=>
      osc_halt != wait_mode) else $error("stop request not taken");
   wake_end_a: assert property ((osc_halt || wait_mode) && wake_irq |=> !osc_halt && !wait_mode)
      else $error("wake did not end stop or wait");
endmodule // wdg_top_monitor
`default_nettype wire

/* bench/wdg_top_tb.sv */
// self-checking bench for the watchdog reset block
`timescale 1ns/100ps
`default_nettype none
module wdg_top_tb;
   import wdg_pkg::*;
   logic mclk, rst_n, ext_reset_n, hw_option, read, write, stop_req, wake_irq, return_from_interrupt, irq_pending;
   logic waitrequest, sys_reset, stack_clear, pc_load, nmi_mode, irq_service, resume_next;
   logic osc_halt, wait_mode;
   logic [11:0] pc_vector;
   logic [7:0] address;
   logic [3:0] byteenable;
   logic [31:0] writedata, readdata, rdv;
   int miscompares, compares, n;
   wdg_top dut_u (
      .mclk(mclk),
      .rst_n(rst_n),
      .ext_reset_n(ext_reset_n),
      .hw_option(hw_option),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .byteenable(byteenable),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .stop_req(stop_req),
      .wake_irq(wake_irq),
      .return_from_interrupt(return_from_interrupt),
      .irq_pending(irq_pending),
      .sys_reset(sys_reset),
      .stack_clear(stack_clear),
      .pc_load(pc_load),
      .pc_vector(pc_vector),
      .nmi_mode(nmi_mode),
      .irq_service(irq_service),
      .resume_next(resume_next),
      .osc_halt(osc_halt),
      .wait_mode(wait_mode)
   );
   // free running system clock
   initial begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // bounded wait on sys_reset or waitrequest; running out ends the run
   task automatic await(input logic on_rst, input logic lvl, input int lim);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while ((on_rst ? sys_reset : waitrequest) !== lvl && n < lim);
      // a level met on the last poll still counts as met
      if ((on_rst ? sys_reset : waitrequest) !== lvl) begin
         miscompares++;
         tally_and_finish();
      end
   endtask
   task automatic wait_rst(input logic lvl, input int lim);
      await(1'h1, lvl, lim);
      @(posedge mclk);
   endtask
   // one bus transfer, held until the rising edge that sees waitrequest low
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      address <= a;
      writedata <= wd;
      write <= wr;
      read <= !wr;
      await(1'h0, 1'h0, 20);
      // read data taken at the edge that sees waitrequest low
      @(posedge mclk);
      rdv = readdata;
      read <= 1'h0;
      write <= 1'h0;
      @(posedge mclk);
   endtask
   task automatic xrd(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'h0, a, 32'h0);
      check("readdata", rdv, exp);
   endtask
   // one-cycle core pulse; mode outputs compared once its edge has landed
   task automatic strobe(input logic [2:0] sel, input logic [4:0] exp);
      {wake_irq, return_from_interrupt, stop_req} <= sel;
      @(posedge mclk);
      {wake_irq, return_from_interrupt, stop_req} <= 3'h0;
      @(negedge mclk);
      check("modes", 32'({nmi_mode, irq_service, resume_next, osc_halt, wait_mode}), 32'(exp));
      @(posedge mclk);
   endtask
   // reset, then each behaviour in turn
   initial begin
      {rst_n, read, write, wake_irq, return_from_interrupt, stop_req, hw_option} = 7'h00;
      {ext_reset_n, irq_pending} = 2'h3;
      {address, writedata, byteenable} = {8'h00, 32'h0, 4'hF};
      miscompares = 0;
      compares = 0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'h1;
      wait_rst(1'h0, 2200);
      xrd(ADDR_COUNT_CTL, 32'(COUNT_CTL_RST));
      xrd(8'h00, 32'h0);
      strobe(3'h2, 5'h08);
      strobe(3'h1, 5'h02);
      strobe(3'h4, 5'h00);
      xfer(1'h1, ADDR_COUNT_CTL, 32'h02);
      repeat (7000) @(negedge mclk);
      check("timer", 32'(sys_reset), 32'h0);
      @(posedge mclk);
      // count field 1 with activation: bit 6 falls on the second step
      xfer(1'h1, ADDR_COUNT_CTL, 32'h83);
      wait_rst(1'h1, 6300);
      check("period", 32'(n > 3070 && n < 6150), 32'h1);
      wait_rst(1'h0, 2200);
      xrd(ADDR_COUNT_CTL, 32'(COUNT_CTL_RST));
      xrd(ADDR_STATUS, 32'h22);
      irq_pending <= 1'h0;
      strobe(3'h2, 5'h04);
      xfer(1'h1, ADDR_COUNT_CTL, 32'hFC);
      wait_rst(1'h1, 4);
      check("soft", 32'(n < 3), 32'h1);
      wait_rst(1'h0, 2200);
      // strap for permanent activation, taken in through the reset pin
      hw_option <= 1'h1;
      ext_reset_n <= 1'h0;
      repeat (3) @(negedge mclk);
      check("pin", 32'(sys_reset), 32'h1);
      @(posedge mclk);
      ext_reset_n <= 1'h1;
      wait_rst(1'h0, 2200);
      xfer(1'h1, ADDR_COUNT_CTL, 32'hFE);
      xrd(ADDR_COUNT_CTL, 32'hFF);
      xrd(ADDR_STATUS, 32'h12);
      strobe(3'h1, 5'h11);
      // reload a two-step period well inside one step, so it never expires
      repeat (4) begin
         xfer(1'h1, ADDR_COUNT_CTL, 32'h83);
         repeat (2000) @(posedge mclk);
      end
      xrd(ADDR_STATUS, 32'h1A);
      // reloads stop, so the short period must now run out
      wait_rst(1'h1, 6300);
      check("expire", 32'(n < 6150), 32'h1);
      tally_and_finish();
   end
endmodule // wdg_top_tb
bind wdg_top wdg_top_monitor mon_u (
   .mclk(mclk),
   .rst_n(rst_n),
   .ext_reset_n(ext_reset_n),
   .address(address),
   .read(read),
   .write(write),
   .writedata(writedata),
   .byteenable(byteenable),
   .waitrequest(waitrequest),
   .stop_req(stop_req),
   .wake_irq(wake_irq),
   .return_from_interrupt(return_from_interrupt),
   .irq_pending(irq_pending),
   .sys_reset(sys_reset),
   .stack_clear(stack_clear),
   .pc_load(pc_load),
   .pc_vector(pc_vector),
   .nmi_mode(nmi_mode),
   .irq_service(irq_service),
   .resume_next(resume_next),
   .osc_halt(osc_halt),
   .wait_mode(wait_mode)
);
`default_nettype wire
